// [src/pso_output_unit.sv]
/*
 pso_output_unit: two dedicated outputs in normal, pwm or compare mode, the first also in stepper mode,
 with an ahb-lite register slave.
 assumes fast counter totals come from logic on hclk; single word transfers only.
*/
`timescale 1ns/1ps
module pso_output_unit
  import pso_pkg::*;
(
  input wire logic hclk, // 100 MHz clock
  input wire logic hresetn, // async reset, low
  input wire logic hsel, // slave select
  input wire logic [31:0] haddr, // byte address
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // write when high
  input wire logic [2:0] hsize, // word only
  input wire logic [31:0] hwdata, // write data
  input wire logic hready, // bus ready in
  input wire logic [31:0] fast_count_first, // first counter total
  input wire logic [31:0] fast_count_second, // second counter total
  output logic hreadyout, // slave ready
  output logic [31:0] hrdata, // read data
  output logic hresp, // always okay
  output logic first_dedicated_output, // first output pin
  output logic second_dedicated_output // second output pin
);
  typedef struct packed {
    logic [7:0] addr_q;
    logic wr_q;
    logic rd_q;
    logic hready;
    logic [31:0] hrdata;
    logic hresp;
    logic [CTRL_W-1:0] ctrl;
    logic [31:0] p1;
    logic [31:0] p2;
    logic [31:0] p3;
    logic [31:0] p4;
    logic [31:0] s_pre;
    logic [31:0] s_per;
    logic [31:0] s_d1;
    logic [31:0] s_d2;
    logic [31:0] pre_cnt;
    logic [31:0] per_cnt;
    logic arm1;
    logic arm2;
    logic out1;
    logic out2;
    pso_step_type st;
    pso_phase_type ph;
    logic [31:0] idx;
    logic [15:0] l_start;
    logic [15:0] l_run;
    logic [31:0] l_acc;
    logic [31:0] l_runc;
    logic [31:0] l_dec;
    logic [15:0] freq;
    logic [26:0] acc;
    logic div_go;
    logic run_d;
    logic sout;
    logic ready;
    logic error;
  } pso_state_type;

  pso_state_type r_reg;
  pso_state_type r_next;

  logic ref_tick;
  logic div_done;
  logic [47:0] div_q;
  logic [47:0] div_num;
  logic [31:0] div_den;
  logic [31:0] ph_cnt;
  logic [15:0] diff;

  // 16 MHz reference as an enable on the 100 MHz clock
  pso_frac_div #(
    .NUM(REF_STEP),
    .DEN(CLK_STEP)
  ) u_ref (
    .hclk(hclk),
    .hresetn(hresetn),
    .tick(ref_tick)
  );

  // ramp steps are far apart, so a slow serial divide is enough
  pso_seq_div #(
    .NW(48),
    .DW(32)
  ) u_div (
    .hclk(hclk),
    .hresetn(hresetn),
    .go(r_reg.div_go),
    .dividend(div_num),
    .divisor(div_den),
    .done(div_done),
    .quotient(div_q)
  );

  function automatic logic step_bad(input logic [31:0] f, input logic [31:0] a,
                                    input logic [31:0] d);
    logic bad;
    bad = 1'b0;
    if (f[31:16] == 16'h0000 || f[31:16] > STEP_FREQ_MAX) begin
      bad = 1'b1;
    end
    if (a == 32'h0000_0001 || d == 32'h0000_0001) begin
      bad = 1'b1;
    end
    if ((a != 32'h0000_0000 || d != 32'h0000_0000) &&
        (f[15:0] == 16'h0000 || f[15:0] > f[31:16])) begin
      bad = 1'b1;
    end
    return bad;
  endfunction : step_bad

  function automatic logic [31:0] read_val(input pso_state_type s);
    logic [31:0] v;
    v = 32'h0000_0000;
    if (s.addr_q == ADDR_CTRL) begin
      v[CTRL_W-1:0] = s.ctrl;
    end else if (s.addr_q == ADDR_PWM_FIRST_DUTY) begin
      v = s.p1;
    end else if (s.addr_q == ADDR_PWM_SECOND_DUTY) begin
      v = s.p2;
    end else if (s.addr_q == ADDR_PWM_PRESCALE) begin
      v = s.p3;
    end else if (s.addr_q == ADDR_PWM_PERIOD) begin
      v = s.p4;
    end else if (s.addr_q == ADDR_STOP_PRESCALE) begin
      v = s.s_pre;
    end else if (s.addr_q == ADDR_STOP_PERIOD) begin
      v = s.s_per;
    end else if (s.addr_q == ADDR_STOP_FIRST_DUTY) begin
      v = s.s_d1;
    end else if (s.addr_q == ADDR_STOP_SECOND_DUTY) begin
      v = s.s_d2;
    end else if (s.addr_q == ADDR_STATUS) begin
      v[STAT_READY] = s.ready;
      v[STAT_ERROR] = s.error;
      v[STAT_OUT1] = s.out1;
      v[STAT_OUT2] = s.out2;
    end
    return v;
  endfunction : read_val

  // divider operands follow the latched values of the current phase
  always_comb begin
    diff = r_reg.l_run - r_reg.l_start;
    if (r_reg.ph == PH_ACCEL) begin
      ph_cnt = r_reg.l_acc;
    end else if (r_reg.ph == PH_RUN) begin
      ph_cnt = r_reg.l_runc;
    end else begin
      ph_cnt = r_reg.l_dec;
    end
    div_num = {32'h0000_0000, diff} * {16'h0000, r_reg.idx};
    div_den = ph_cnt - 32'h0000_0001;
  end

  pso_mode_type mode1;
  pso_mode_type mode2;
  logic stop;
  logic use_stop;
  logic freeze;
  logic run_bit;
  logic [31:0] e_pre;
  logic [31:0] e_per;
  logic [31:0] e_d1;
  logic [31:0] e_d2;
  logic hi1;
  logic hi2;
  logic pwm1;
  logic pwm2;
  logic cmp1;
  logic cmp2;
  logic [26:0] acc_sum;

  always_comb begin
    r_next = r_reg;
    r_next.div_go = 1'b0;
    mode1 = pso_mode_type'(r_reg.ctrl[CTRL_MODE1_LSB+:2]);
    mode2 = pso_mode_type'(r_reg.ctrl[CTRL_MODE2_LSB+:2]);
    stop = r_reg.ctrl[CTRL_STOP];
    use_stop = stop && !r_reg.ctrl[CTRL_HOLD];
    freeze = stop && r_reg.ctrl[CTRL_HOLD];
    run_bit = r_reg.ctrl[CTRL_OUT1] && (mode1 == MODE_STEPPER);
    r_next.run_d = run_bit;
    acc_sum = r_reg.acc + {11'h000, r_reg.freq};

    // bus slave: writes land in the data phase, reads take one wait state
    r_next.wr_q = 1'b0;
    r_next.rd_q = 1'b0;
    r_next.hready = 1'b1;
    if (r_reg.wr_q) begin
      if (r_reg.addr_q == ADDR_CTRL) begin
        r_next.ctrl = hwdata[CTRL_W-1:0];
      end else if (r_reg.addr_q == ADDR_PWM_FIRST_DUTY) begin
        r_next.p1 = hwdata;
      end else if (r_reg.addr_q == ADDR_PWM_SECOND_DUTY) begin
        r_next.p2 = hwdata;
      end else if (r_reg.addr_q == ADDR_PWM_PRESCALE) begin
        r_next.p3 = hwdata;
      end else if (r_reg.addr_q == ADDR_PWM_PERIOD) begin
        r_next.p4 = hwdata;
      end else if (r_reg.addr_q == ADDR_STOP_PRESCALE) begin
        r_next.s_pre = hwdata;
      end else if (r_reg.addr_q == ADDR_STOP_PERIOD) begin
        r_next.s_per = hwdata;
      end else if (r_reg.addr_q == ADDR_STOP_FIRST_DUTY) begin
        r_next.s_d1 = hwdata;
      end else if (r_reg.addr_q == ADDR_STOP_SECOND_DUTY) begin
        r_next.s_d2 = hwdata;
      end
    end
    if (r_reg.rd_q) begin
      r_next.hrdata = read_val(r_reg);
    end
    if (hsel && htrans[1] && hready) begin
      r_next.addr_q = haddr[7:0];
      if (haddr[31:8] != 24'h00_0000) begin
        r_next.addr_q = 8'hff; // outside the map: reads zero, writes dropped
      end
      r_next.wr_q = hwrite;
      r_next.rd_q = !hwrite;
      r_next.hready = hwrite;
    end
    r_next.hresp = 1'b0;

    // pwm timebase, one counter shared by both channels
    if (use_stop) begin
      e_pre = r_reg.s_pre;
      e_per = r_reg.s_per;
      e_d1 = r_reg.s_d1;
      e_d2 = r_reg.s_d2;
    end else begin
      e_pre = r_reg.p3;
      e_per = r_reg.p4;
      e_d1 = r_reg.p1;
      e_d2 = r_reg.p2;
    end
    if (!freeze && ref_tick) begin
      if (r_reg.pre_cnt >= e_pre) begin
        r_next.pre_cnt = 32'h0000_0000;
        if ({1'b0, r_reg.per_cnt} + 33'h0_0000_0001 >= {1'b0, e_per}) begin
          r_next.per_cnt = 32'h0000_0000;
        end else begin
          r_next.per_cnt = r_reg.per_cnt + 32'h0000_0001;
        end
      end else begin
        r_next.pre_cnt = r_reg.pre_cnt + 32'h0000_0001;
      end
    end
    hi1 = (e_per != 32'h0000_0000) && (r_reg.per_cnt < e_d1);
    hi2 = (e_per != 32'h0000_0000) && (r_reg.per_cnt < e_d2);
    if (r_reg.ctrl[CTRL_LOAD]) begin
      r_next.arm1 = 1'b0;
      r_next.arm2 = 1'b0;
    end else begin
      if (r_reg.p4 != 32'h0000_0000 && r_reg.p1 != 32'h0000_0000) begin
        r_next.arm1 = 1'b1;
      end
      if (r_reg.p4 != 32'h0000_0000 && r_reg.p2 != 32'h0000_0000) begin
        r_next.arm2 = 1'b1;
      end
    end
    if (freeze) begin
      pwm1 = r_reg.out1;
      pwm2 = r_reg.out2;
    end else if (use_stop) begin
      pwm1 = hi1;
      pwm2 = hi2;
    end else begin
      pwm1 = r_reg.arm1 && hi1;
      pwm2 = r_reg.arm2 && hi2;
    end

    // counter compare, zero preset keeps the output low
    cmp1 = (r_reg.p1 != 32'h0000_0000) && (fast_count_first >= r_reg.p1);
    cmp2 = (r_reg.p2 != 32'h0000_0000) && (fast_count_second >= r_reg.p2);

    // stepper sequencer
    case (r_reg.st)
      ST_IDLE: begin
        r_next.sout = 1'b0;
        r_next.ready = 1'b1;
        if (run_bit && !r_reg.run_d && !stop) begin
          if (step_bad(r_reg.p1, r_reg.p2, r_reg.p4)) begin
            r_next.error = 1'b1;
          end else begin
            r_next.error = 1'b0;
            r_next.l_start = r_reg.p1[15:0];
            r_next.l_run = r_reg.p1[31:16];
            r_next.l_acc = r_reg.p2;
            r_next.l_runc = r_reg.p3;
            r_next.l_dec = r_reg.p4;
            r_next.ph = PH_ACCEL;
            r_next.idx = 32'h0000_0000;
            r_next.ready = 1'b0;
            r_next.st = ST_CHECK;
          end
        end
      end
      ST_CHECK: begin
        if (r_reg.idx == ph_cnt) begin
          r_next.idx = 32'h0000_0000;
          if (r_reg.ph == PH_ACCEL) begin
            r_next.ph = PH_RUN;
          end else if (r_reg.ph == PH_RUN) begin
            r_next.ph = PH_DECEL;
          end else begin
            r_next.st = ST_IDLE;
            r_next.ready = 1'b1;
          end
        end else begin
          r_next.st = ST_CALC;
        end
      end
      ST_CALC: begin
        if (r_reg.ph == PH_RUN) begin
          r_next.freq = r_reg.l_run;
          r_next.acc = 27'h000_0000;
          r_next.sout = 1'b1;
          r_next.st = ST_HIGH;
        end else begin
          r_next.div_go = 1'b1;
          r_next.st = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (div_done) begin
          if (r_reg.ph == PH_ACCEL) begin
            r_next.freq = r_reg.l_start + div_q[15:0];
          end else begin
            r_next.freq = r_reg.l_run - div_q[15:0];
          end
          r_next.acc = 27'h000_0000;
          r_next.sout = 1'b1;
          r_next.st = ST_HIGH;
        end
      end
      ST_HIGH: begin
        if (acc_sum >= HALF_CYCLE_NUM) begin
          r_next.acc = 27'h000_0000;
          r_next.sout = 1'b0;
          r_next.st = ST_LOW;
        end else begin
          r_next.acc = acc_sum;
        end
      end
      ST_LOW: begin
        if (acc_sum >= HALF_CYCLE_NUM) begin
          r_next.acc = 27'h000_0000;
          r_next.idx = r_reg.idx + 32'h0000_0001;
          r_next.st = ST_CHECK;
        end else begin
          r_next.acc = acc_sum;
        end
      end
      default: begin
        r_next.st = ST_IDLE;
      end
    endcase
    if (r_reg.st != ST_IDLE) begin
      if (stop) begin
        r_next.st = ST_IDLE;
        r_next.sout = 1'b0;
        r_next.ready = 1'b1;
      end else if (!run_bit) begin
        r_next.st = ST_IDLE;
        r_next.sout = 1'b0;
        r_next.error = 1'b1;
        r_next.ready = 1'b1;
      end
    end

    // output selection per channel
    case (mode1)
      MODE_NORMAL: r_next.out1 = r_reg.ctrl[CTRL_OUT1];
      MODE_PWM: r_next.out1 = pwm1;
      MODE_COMPARE: r_next.out1 = cmp1;
      default: r_next.out1 = r_next.sout && !stop;
    endcase
    if (mode1 == MODE_STEPPER) begin
      r_next.out2 = r_reg.ctrl[CTRL_OUT2];
    end else begin
      case (mode2)
        MODE_PWM: r_next.out2 = pwm2;
        MODE_COMPARE: r_next.out2 = cmp2;
        default: r_next.out2 = r_reg.ctrl[CTRL_OUT2];
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r_reg <= '0;
      r_reg.hready <= 1'b1;
      r_reg.ready <= 1'b1;
      r_reg.ctrl <= CTRL_RESET;
      r_reg.p1 <= PARAM_RESET;
      r_reg.st <= ST_IDLE;
      r_reg.ph <= PH_ACCEL;
    end else begin
      r_reg <= r_next;
    end
  end

  assign hreadyout = r_reg.hready;
  assign hrdata = r_reg.hrdata;
  assign hresp = r_reg.hresp;
  assign first_dedicated_output = r_reg.out1;
  assign second_dedicated_output = r_reg.out2;
endmodule : pso_output_unit

// [src/pso_pkg.sv]
/*
 pso_pkg: constants, register map and types of the two-output pwm/stepper unit.
 assumes a 100 MHz bus clock and software access over ahb-lite.
*/
package pso_pkg;
  localparam int CLK_HZ = 100_000_000;
  localparam int REF_HZ = 16_000_000;
  localparam int CLK_STEP = CLK_HZ / 1_000_000;
  localparam int REF_STEP = REF_HZ / 1_000_000;
  localparam logic [26:0] HALF_CYCLE_NUM = 27'(CLK_HZ / 2);
  localparam logic [15:0] STEP_FREQ_MAX = 16'h1388;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_PWM_FIRST_DUTY = 8'h04;
  localparam logic [7:0] ADDR_PWM_SECOND_DUTY = 8'h08;
  localparam logic [7:0] ADDR_PWM_PRESCALE = 8'h0c;
  localparam logic [7:0] ADDR_PWM_PERIOD = 8'h10;
  localparam logic [7:0] ADDR_STOP_PRESCALE = 8'h14;
  localparam logic [7:0] ADDR_STOP_PERIOD = 8'h18;
  localparam logic [7:0] ADDR_STOP_FIRST_DUTY = 8'h1c;
  localparam logic [7:0] ADDR_STOP_SECOND_DUTY = 8'h20;
  localparam logic [7:0] ADDR_STATUS = 8'h24;
  localparam int CTRL_MODE1_LSB = 0;
  localparam int CTRL_MODE2_LSB = 2;
  localparam int CTRL_OUT1 = 4;
  localparam int CTRL_OUT2 = 5;
  localparam int CTRL_STOP = 6;
  localparam int CTRL_HOLD = 7;
  localparam int CTRL_LOAD = 8;
  localparam int CTRL_W = 9;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 9'h000;
  localparam logic [31:0] PARAM_RESET = 32'h0000_0000;
  localparam int STAT_READY = 0;
  localparam int STAT_ERROR = 1;
  localparam int STAT_OUT1 = 2;
  localparam int STAT_OUT2 = 3;
  typedef enum logic [1:0] {MODE_NORMAL, MODE_PWM, MODE_COMPARE, MODE_STEPPER} pso_mode_type;
  typedef enum logic [1:0] {PH_ACCEL, PH_RUN, PH_DECEL} pso_phase_type;
  typedef enum logic [2:0] {ST_IDLE, ST_CHECK, ST_CALC, ST_WAIT, ST_HIGH, ST_LOW} pso_step_type;
endpackage : pso_pkg

// [src/pso_frac_div.sv]
/*
 pso_frac_div: fractional divider giving a one-cycle enable at num/den of the clock.
 assumes num below den; the pulse spacing jitters by one cycle.
*/
`timescale 1ns/1ps
module pso_frac_div #(
  parameter int NUM = 16,
  parameter int DEN = 100
) (
  input wire logic hclk, // bus clock
  input wire logic hresetn, // async reset, low
  output logic tick // one-cycle enable
);
  localparam int AW = $clog2(DEN) + 1;
  typedef struct packed {
    logic [AW-1:0] acc;
    logic tick;
  } pso_fd_type;
  pso_fd_type r_reg;
  pso_fd_type r_next;
  logic [AW:0] sum;

  always_comb begin
    r_next = r_reg;
    sum = {1'b0, r_reg.acc} + (AW+1)'(NUM);
    r_next.tick = 1'b0;
    if (sum >= (AW+1)'(DEN)) begin
      sum = sum - (AW+1)'(DEN);
      r_next.tick = 1'b1;
    end
    r_next.acc = sum[AW-1:0];
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign tick = r_reg.tick;
endmodule : pso_frac_div

// [src/pso_seq_div.sv]
/*
 pso_seq_div: serial restoring divider, one quotient bit per clock.
 assumes divisor non-zero and go only while idle; done pulses once.
*/
`timescale 1ns/1ps
module pso_seq_div #(
  parameter int NW = 48,
  parameter int DW = 32
) (
  input wire logic hclk, // bus clock
  input wire logic hresetn, // async reset, low
  input wire logic go, // start pulse
  input wire logic [NW-1:0] dividend, // numerator
  input wire logic [DW-1:0] divisor, // denominator
  output logic done, // result pulse
  output logic [NW-1:0] quotient // result
);
  localparam int CW = $clog2(NW + 1);
  typedef struct packed {
    logic busy;
    logic done;
    logic [CW-1:0] cnt;
    logic [DW:0] rem;
    logic [NW-1:0] quo;
    logic [DW-1:0] den;
  } pso_dv_type;
  pso_dv_type r_reg;
  pso_dv_type r_next;
  logic [DW:0] sh;

  always_comb begin
    r_next = r_reg;
    r_next.done = 1'b0;
    sh = {r_reg.rem[DW-1:0], r_reg.quo[NW-1]};
    if (go && !r_reg.busy) begin
      r_next.busy = 1'b1;
      r_next.cnt = CW'(NW);
      r_next.rem = '0;
      r_next.quo = dividend;
      r_next.den = divisor;
    end else if (r_reg.busy) begin
      r_next.quo = {r_reg.quo[NW-2:0], 1'b0};
      if (sh >= {1'b0, r_reg.den}) begin
        sh = sh - {1'b0, r_reg.den};
        r_next.quo[0] = 1'b1;
      end
      r_next.rem = sh;
      r_next.cnt = r_reg.cnt - 1'b1;
      if (r_reg.cnt == CW'(1)) begin
        r_next.busy = 1'b0;
        r_next.done = 1'b1;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign done = r_reg.done;
  assign quotient = r_reg.quo;
endmodule : pso_seq_div

// [test/pso_output_unit_checker.sv]
/* pso_output_unit_checker: port assertions for the two-output unit.
 assumes one ahb master; register shadows are rebuilt from bus traffic. */
`timescale 1ns/1ps
module pso_output_unit_checker
  import pso_pkg::*;
(
  input wire logic hclk, // clock
  input wire logic hresetn, // reset, low
  input wire logic hsel, // select
  input wire logic [31:0] haddr, // address
  input wire logic [1:0] htrans, // type
  input wire logic hwrite, // write
  input wire logic [2:0] hsize, // size
  input wire logic [31:0] hwdata, // write data
  input wire logic hready, // ready in
  input wire logic [31:0] fast_count_first, // total 1
  input wire logic [31:0] fast_count_second, // total 2
  input wire logic hreadyout, // ready out
  input wire logic [31:0] hrdata, // read data
  input wire logic hresp, // response
  input wire logic first_dedicated_output, // pin 1
  input wire logic second_dedicated_output // pin 2
);
  logic pend_reg;
  logic [7:0] wa_reg;
  logic [CTRL_W-1:0] ctrl_reg;
  logic [31:0] duty_reg;
  logic take;
  logic stop;
  logic [1:0] m1;
  assign take = hsel & htrans[1] & hready;
  assign stop = ctrl_reg[CTRL_STOP];
  assign m1 = ctrl_reg[1:0];
  // unmapped writes are dropped by the slave, so the shadows skip them too
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pend_reg <= 1'b0;
      wa_reg <= 8'h00;
      ctrl_reg <= CTRL_RESET;
      duty_reg <= PARAM_RESET;
    end else begin
      pend_reg <= take & hwrite & (haddr[31:8] == 24'h000000);
      wa_reg <= haddr[7:0];
      if (pend_reg && hready && wa_reg == ADDR_CTRL) ctrl_reg <= hwdata[CTRL_W-1:0];
      if (pend_reg && hready && wa_reg == ADDR_PWM_FIRST_DUTY) duty_reg <= hwdata;
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("error response seen");
  a_read_wait: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  a_normal_first: assert property (m1 == 2'd0 && !stop
    |=> first_dedicated_output == $past(ctrl_reg[CTRL_OUT1])) else $error("pin 1 not bit");
  a_second_plain: assert property ((ctrl_reg[3:2] == 2'd0 || m1 == 2'd3) && !stop
    |=> second_dedicated_output == $past(ctrl_reg[CTRL_OUT2])) else $error("pin 2 not bit");
  a_compare_drive: assert property (m1 == 2'd2 && !stop |=>
    first_dedicated_output == ($past(duty_reg) != 32'h0 && $past(fast_count_first) >=
    $past(duty_reg))) else $error("compare output wrong");
  a_pwm_zero_duty: assert property (m1 == 2'd1 && !stop && duty_reg == 32'h0
    && $past(duty_reg) == 32'h0 |-> !first_dedicated_output) else $error("zero duty high");
  a_step_stop_low: assert property (m1 == 2'd3 && stop && $past(stop)
    && $past(m1) == 2'd3 |-> !first_dedicated_output) else $error("stepper pin high in stop");
  a_step_abort_low: assert property (m1 == 2'd3 && !ctrl_reg[CTRL_OUT1]
    && !$past(ctrl_reg[CTRL_OUT1]) && $past(m1) == 2'd3 |-> !first_dedicated_output)
    else $error("pin high no run");
  c_compare_high: cover property (m1 == 2'd2 && first_dedicated_output);
  c_step_pulse: cover property (m1 == 2'd3 && first_dedicated_output);
  c_pwm_both: cover property (m1 == 2'd1 && first_dedicated_output && second_dedicated_output);
endmodule : pso_output_unit_checker

bind pso_output_unit pso_output_unit_checker u_chk (.hclk, .hresetn, .hsel, .haddr, .htrans,
  .hwrite, .hsize, .hwdata, .hready, .fast_count_first, .fast_count_second, .hreadyout,
  .hrdata, .hresp, .first_dedicated_output, .second_dedicated_output);

// [test/pso_load_model.sv]
/* pso_load_model: load on the two dedicated pins, timing their pulses.
 assumes clean registered levels on hclk; counts from time zero. */
`timescale 1ns/1ps
module pso_load_model (
  input wire logic hclk, // clock
  input wire logic first_in, // pin 1
  input wire logic second_in, // pin 2
  output int rises, // rises on pin 1
  output int high_w, // last high time on pin 1
  output int per_w, // last rise to rise on pin 1
  output int rise_a, // clock of last rise, pin 1
  output int rise_b // clock of last rise, pin 2
);
  int now = 0;
  logic a_q = 1'b0;
  logic b_q = 1'b0;
  always @(posedge hclk) begin
    now <= now + 1;
    if (first_in && !a_q) begin
      rises <= rises + 1;
      per_w <= now - rise_a;
      rise_a <= now;
    end
    if (!first_in && a_q) high_w <= now - rise_a;
    if (second_in && !b_q) rise_b <= now;
    a_q <= first_in;
    b_q <= second_in;
  end
endmodule : pso_load_model

// [test/pso_output_unit_tb_top.sv]
/* pso_output_unit_tb_top: self-checking bench for the two-output unit.
 assumes the unit is the only ahb slave and a load model sits on the pins. */
`timescale 1ns/1ps
module pso_output_unit_tb_top;
  import pso_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] fc1 = 32'h0;
  logic [31:0] fc2 = 32'h0;
  logic [31:0] seed = 32'h12cd6;
  logic [31:0] q, p, f, d1, d2;
  logic [1:0] s;
  logic [15:0] bad [6][5];
  int n_errors = 0;
  int checked = 0;
  int r0, rises, high_w, per_w, rise_a, rise_b;
  wire logic hreadyout, hresp, out1, out2;
  wire logic [31:0] hrdata;
  always #5 hclk = ~hclk;
  pso_output_unit u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .fast_count_first(fc1), .fast_count_second(fc2), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .first_dedicated_output(out1), .second_dedicated_output(out2));
  pso_load_model u_load (.hclk(hclk), .first_in(out1), .second_in(out2), .rises(rises),
    .high_w(high_w), .per_w(per_w), .rise_a(rise_a), .rise_b(rise_b));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  function automatic int pw(input logic [31:0] d);
    return int'(d) * CLK_STEP / REF_STEP;
  endfunction : pw
  // one clock of reference jitter on each edge
  function automatic logic [31:0] near(input int got, input int exp);
    return (got >= exp - 2 && got <= exp + 2) ? 32'(exp) : 32'(got);
  endfunction : near
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, {24'h0, a}, d);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    bus(1'b0, {24'h0, a}, 32'h0);
  endtask : rd
  task automatic pins(input string what, input logic [1:0] exp);
    repeat (3) @(posedge hclk);
    #1;
    chk(what, {30'h0, exp}, {30'h0, out2, out1});
  endtask : pins
  task automatic rst(input int n);
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (n) @(posedge hclk);
    hresetn <= 1'b1;
  endtask : rst
  task automatic step_go(input logic [15:0] st, input logic [15:0] ru, input logic [15:0] a,
    input logic [15:0] n, input logic [15:0] d);
    wr(ADDR_PWM_FIRST_DUTY, {ru, st});
    wr(ADDR_PWM_SECOND_DUTY, 32'(a));
    wr(ADDR_PWM_PRESCALE, 32'(n));
    wr(ADDR_PWM_PERIOD, 32'(d));
    wr(ADDR_CTRL, 32'h3);
    wr(ADDR_CTRL, 32'h13);
    rd(ADDR_STATUS);
  endtask : step_go
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : wrap_up
  initial begin
    #800000;
    n_errors++;
    wrap_up();
  end
  initial begin
    bad = '{'{16'h1388, 16'h1389, 16'h0, 16'h2, 16'h0}, '{16'h1388, 16'h0, 16'h0, 16'h2, 16'h0},
      '{16'h0, 16'h1388, 16'h2, 16'h0, 16'h0}, '{16'h1388, 16'h0fa0, 16'h0, 16'h0, 16'h2},
      '{16'h0fa0, 16'h1388, 16'h1, 16'h0, 16'h0}, '{16'h0fa0, 16'h1388, 16'h0, 16'h0, 16'h1}};
    rst(12);
    for (int a = 0; a < 36; a += 4) begin
      rd(8'(a));
      chk("reset value", 32'h0, q);
    end
    rd(ADDR_STATUS);
    chk("status after reset", 32'h1, q);
    bus(1'b1, 32'h100, 32'hffff_ffff);
    bus(1'b0, 32'h100, 32'h0);
    chk("unmapped read", 32'h0, q);
    for (int a = 4; a < 36; a += 4) begin
      d1 = rnd();
      wr(8'(a), d1);
      rd(8'(a));
      chk("readback", d1, q);
    end
    $display("test registers finished");
    rst(3);
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_CTRL, 32'(i) << 4);
      pins("normal", 2'(i));
    end
    wr(ADDR_CTRL, 32'ha);
    for (int i = 0; i < 8; i++) begin
      p = rnd() & 32'hff;
      f = p + (rnd() & 32'h7) - 32'h4;
      wr(ADDR_PWM_FIRST_DUTY, p);
      wr(ADDR_PWM_SECOND_DUTY, i[0] ? 32'h0 : p);
      @(posedge hclk);
      fc1 <= f;
      fc2 <= p + 32'h1;
      pins("compare", {!i[0] && p != 0, p != 0 && f >= p});
    end
    $display("test normal and compare finished");
    wr(ADDR_CTRL, 32'h5);
    d1 = 32'h1 + rnd() % 15;
    d2 = 32'h1 + rnd() % 15;
    wr(ADDR_PWM_FIRST_DUTY, d1);
    wr(ADDR_PWM_SECOND_DUTY, d2);
    pins("unarmed", 2'b00);
    wr(ADDR_PWM_PERIOD, 32'h10);
    repeat (400) @(posedge hclk);
    chk("first high", 32'(pw(d1)), near(high_w, pw(d1)));
    chk("period", 32'(pw(32'h10)), near(per_w, pw(32'h10)));
    chk("aligned rise", 32'(rise_a), 32'(rise_b));
    wr(ADDR_PWM_FIRST_DUTY, 32'h0);
    pins("zero duty", {out2, 1'b0});
    wr(ADDR_PWM_FIRST_DUTY, 32'h10);
    pins("full duty", {out2, 1'b1});
    wr(ADDR_CTRL, 32'h105);
    pins("download", 2'b00);
    wr(ADDR_STOP_PERIOD, 32'h10);
    wr(ADDR_STOP_SECOND_DUTY, 32'h10);
    wr(ADDR_CTRL, 32'h45);
    repeat (50) @(posedge hclk);
    pins("stop values", 2'b10);
    wr(ADDR_CTRL, 32'h5);
    wr(ADDR_CTRL, 32'hc5);
    repeat (3) @(posedge hclk);
    s = {out2, out1};
    repeat (300) @(posedge hclk);
    chk("stop hold", {30'h0, s}, {30'h0, out2, out1});
    $display("test pwm finished");
    for (int i = 0; i < 6; i++) begin
      step_go(bad[i][0], bad[i][1], bad[i][2], bad[i][3], bad[i][4]);
      chk("bad start", 32'h3, q & 32'h3);
    end
    r0 = rises;
    step_go(STEP_FREQ_MAX, STEP_FREQ_MAX, 16'h0, 16'h2, 16'h0);
    chk("started", 32'h0, q & 32'h3);
    wr(ADDR_PWM_PRESCALE, 32'h64);
    for (int i = 0; i < 20000 && q[0] !== 1'b1; i++) rd(ADDR_STATUS);
    chk("done", 32'h1, q & 32'h3);
    chk("steps", 32'h2, 32'(rises - r0));
    chk("step high", 32'(pw(32'h0)) + ((HALF_CYCLE_NUM + STEP_FREQ_MAX - 1) / STEP_FREQ_MAX),
      near(high_w, int'((HALF_CYCLE_NUM + STEP_FREQ_MAX - 1) / STEP_FREQ_MAX)));
    step_go(STEP_FREQ_MAX, STEP_FREQ_MAX, 16'h0, 16'h2, 16'h0);
    repeat (100) @(posedge hclk);
    wr(ADDR_CTRL, 32'h3);
    rd(ADDR_STATUS);
    chk("abort", 32'h3, q & 32'h7);
    step_go(STEP_FREQ_MAX, STEP_FREQ_MAX, 16'h0, 16'h2, 16'h0);
    repeat (100) @(posedge hclk);
    wr(ADDR_CTRL, 32'h53);
    rd(ADDR_STATUS);
    chk("stop abort", 32'h1, q & 32'h7);
    $display("test stepper finished");
    wrap_up();
  end
endmodule : pso_output_unit_tb_top
